// >>> verilog/pci_initiator.v
// Summary of operation
// - Complete reads with ready on edge three to six
// - Hold write data until target takes it
// - Each word moves once under toggling ready
// - Target parity error on write sets status
// - Drive parity error two clocks after read phase
// - Bad read parity on single phase sets status
// - Bursts and line reads also check parity
// - Burst and invalidate writes honour target error
// - Early stop ends bursts before fourth phase, except configuration and write and invalidate
// - Configuration cycles are never cut early
// - Dual address commands are refused
// - Write and invalidate ends on line boundary
`timescale 1ns/10ps
`default_nettype none
`include "pci_init_consts.vh"

module pci_initiator (
	input  wire        clk,
	input  wire        resetn,
	input  wire        req_valid,
	output wire        req_ready,
	input  wire [3:0]  req_cmd,
	input  wire [31:0] req_addr,
	input  wire [3:0]  req_be_n,
	input  wire [7:0]  req_len,
	input  wire        req_early_stop,
	input  wire [31:0] wr_data,
	input  wire        wr_valid,
	output wire        wr_ready,
	output reg  [31:0] rd_data,
	output reg         rd_valid,
	output reg         done,
	output reg  [7:0]  xfer_count,
	output reg         master_abort,
	output reg         parity_error_detected,
	input  wire        parity_error_clear,
	output wire        busy,
	output wire        frame_n_out,
	output reg         frame_n_oe_n,
	output wire        irdy_n_out,
	output reg         irdy_n_oe_n,
	input  wire [31:0] ad_in,
	output reg  [31:0] ad_out,
	output reg         ad_oe_n,
	output reg  [3:0]  cbe_n_out,
	output reg         cbe_n_oe_n,
	input  wire        par_in,
	output reg         par_out,
	output reg         par_oe_n,
	input  wire        perr_n_in,
	output reg         perr_n_out,
	output reg         perr_n_oe_n,
	input  wire        trdy_n,
	input  wire        devsel_n,
	input  wire        stop_n
);

	localparam S_IDLE = 2'b00;
	localparam S_ADDR = 2'b01;
	localparam S_DATA = 2'b10;
	localparam S_TURN = 2'b11;

	reg  [1:0]  state;
	reg         frame_q;
	reg         irdy_q;
	reg         is_write;
	reg  [7:0]  len;
	reg         data_full;
	reg  [7:0]  loaded;
	reg  [2:0]  devsel_wait;
	reg         rd_check;
	reg  [35:0] rd_capture;
	reg  [1:0]  wr_tail;
	reg  [7:0]  eff_len;
	reg         next_frame;
	reg         next_irdy;
	reg         finish;

	wire xfer     = irdy_q & ~trdy_n;
	wire stop_hit = irdy_q & ~stop_n & ~devsel_n;
	wire timeout  = (devsel_wait == `DEVSEL_TIMEOUT);
	wire last     = (xfer_count + 8'h01 == len);
	wire load     = wr_ready & wr_valid;
	wire is_cfg   = (req_cmd == `CMD_CFG_RD) | (req_cmd == `CMD_CFG_WR);
	wire start    = req_valid & req_ready;

	// Target parity lands a clock after the word; flag it on that same edge
	wire perr_drive = rd_check & (^{rd_capture, par_in});

	assign req_ready   = (state == S_IDLE) & (req_cmd != `CMD_DUAL_ADDR);
	assign busy        = (state != S_IDLE);
	assign frame_n_out = ~frame_q;
	assign irdy_n_out  = ~irdy_q;
	// Fetch a word only when the held one is empty or leaving this edge
	assign wr_ready    = is_write & ((state == S_ADDR) | (state == S_DATA)) &
	                     (loaded != len) & (~data_full | xfer);

	////////////////////////////////////////////////////////////////////////
	// Effective burst length chosen at request time
	always @* begin
		eff_len = (req_len == 8'h00) ? 8'h01 : req_len;
		if (req_cmd == `CMD_MEM_WR_INV) begin
			// Whole cache lines only, never less than one
			eff_len = {req_len[7:`LINE_SHIFT], 3'b000};
			if (eff_len == 8'h00)
				eff_len = `LINE_WORDS;
		end else if (req_early_stop && !is_cfg && eff_len > `EARLY_STOP_WORDS) begin
			eff_len = `EARLY_STOP_WORDS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next frame and ready levels during the data phases
	always @* begin
		finish     = 1'b0;
		next_frame = frame_q;
		next_irdy  = irdy_q;
		if (state == S_DATA) begin
			if ((xfer && last) || ((stop_hit || timeout) && !frame_q)) begin
				finish     = 1'b1;
				next_frame = 1'b0;
				next_irdy  = 1'b0;
			end else if (stop_hit || timeout) begin
				// Drop frame, keep ready up so the final phase can close
				next_frame = 1'b0;
				next_irdy  = 1'b1;
			end else begin
				// Read waits come from the target; writes also wait for data, and ready stays until the word moves
				next_irdy = is_write ? ((data_full & ~xfer) | load) : 1'b1;
				if (next_irdy && (xfer_count + {7'h00, xfer} + 8'h01 == len))
					next_frame = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transaction sequencer and bus drivers
	always @(posedge clk) begin
		if (!resetn) begin
			state        <= S_IDLE;
			frame_q      <= 1'b0;
			irdy_q       <= 1'b0;
			is_write     <= 1'b0;
			len          <= 8'h00;
			data_full    <= 1'b0;
			loaded       <= 8'h00;
			devsel_wait  <= 3'h0;
			xfer_count   <= 8'h00;
			done         <= 1'b0;
			master_abort <= 1'b0;
			frame_n_oe_n <= 1'b1;
			irdy_n_oe_n  <= 1'b1;
			ad_out       <= 32'h00000000;
			ad_oe_n      <= 1'b1;
			cbe_n_out    <= 4'hF;
			cbe_n_oe_n   <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state)
			S_IDLE: begin
				frame_n_oe_n <= 1'b1;
				irdy_n_oe_n  <= 1'b1;
				if (start) begin
					state        <= S_ADDR;
					frame_q      <= 1'b1;
					frame_n_oe_n <= 1'b0;
					irdy_n_oe_n  <= 1'b0;
					is_write     <= req_cmd[0];
					len          <= eff_len;
					loaded       <= 8'h00;
					xfer_count   <= 8'h00;
					master_abort <= 1'b0;
					devsel_wait  <= 3'h0;
					ad_out       <= req_addr;
					ad_oe_n      <= 1'b0;
					cbe_n_out    <= req_cmd;
					cbe_n_oe_n   <= 1'b0;
				end
			end
			S_ADDR: begin
				state     <= S_DATA;
				cbe_n_out <= req_be_n;
				ad_oe_n   <= ~is_write; // Reads turn the bus around here
				irdy_q    <= is_write ? load : 1'b1;
				frame_q   <= ~(len == 8'h01 && (load || !is_write));
				if (load) begin
					ad_out    <= wr_data;
					data_full <= 1'b1;
					loaded    <= loaded + 8'h01;
				end
			end
			S_DATA: begin
				frame_q <= next_frame;
				irdy_q  <= next_irdy;
				if (!devsel_n)
					devsel_wait <= 3'h0;
				else if (xfer_count == 8'h00 && !timeout)
					devsel_wait <= devsel_wait + 3'h1;
				if (xfer)
					xfer_count <= xfer_count + 8'h01;
				// Write word only replaced once the target took it
				if (load) begin
					ad_out    <= wr_data;
					data_full <= 1'b1;
					loaded    <= loaded + 8'h01;
				end else if (xfer) begin
					data_full <= 1'b0;
				end
				if (finish) begin
					state        <= S_TURN;
					master_abort <= timeout;
					ad_oe_n      <= 1'b1;
					cbe_n_oe_n   <= 1'b1;
					data_full    <= 1'b0;
				end
			end
			S_TURN: begin
				// Frame and ready already high; release next clock
				state <= S_IDLE;
				done  <= 1'b1;
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parity generation, read checking and error reporting
	always @(posedge clk) begin
		if (!resetn) begin
			par_out               <= 1'b0;
			par_oe_n              <= 1'b1;
			rd_data               <= 32'h00000000;
			rd_valid              <= 1'b0;
			rd_check              <= 1'b0;
			rd_capture            <= 36'h000000000;
			perr_n_out            <= 1'b1;
			perr_n_oe_n           <= 1'b1;
			wr_tail               <= 2'h0;
			parity_error_detected <= 1'b0;
		end else begin
			// Parity trails address and data by one clock
			par_out  <= ^{ad_out, cbe_n_out};
			par_oe_n <= ad_oe_n;
			rd_valid <= 1'b0;
			rd_check <= 1'b0;
			if (state == S_DATA && !is_write && xfer) begin
				rd_data    <= ad_in;
				rd_valid   <= 1'b1;
				rd_check   <= 1'b1;
				rd_capture <= {ad_in, cbe_n_out};
			end
			// Pin low two clocks after the word; a later drive would miss the target
			if (perr_drive) begin
				perr_n_out  <= 1'b0;
				perr_n_oe_n <= 1'b0;
			end else if (!perr_n_out) begin
				perr_n_out <= 1'b1;
			end else begin
				perr_n_oe_n <= 1'b1;
			end
			// Target error report can trail the last write phase by two clocks
			if (state == S_DATA && is_write)
				wr_tail <= 2'h3;
			else if (wr_tail != 2'h0)
				wr_tail <= wr_tail - 2'h1;
			// Set wins over a clear in the same clock
			if ((perr_drive) ||
			    ((state == S_DATA && is_write) || wr_tail != 2'h0) && !perr_n_in)
				parity_error_detected <= 1'b1;
			else if (parity_error_clear)
				parity_error_detected <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> common/pci_init_consts.vh
`ifndef PCI_INIT_CONSTS_VH
`define PCI_INIT_CONSTS_VH

// Bus command codes
`define CMD_IO_RD        4'h2
`define CMD_IO_WR        4'h3
`define CMD_MEM_RD       4'h6
`define CMD_MEM_WR       4'h7
`define CMD_CFG_RD       4'hA
`define CMD_CFG_WR       4'hB
`define CMD_MEM_RD_MULT  4'hC
`define CMD_DUAL_ADDR    4'hD
`define CMD_MEM_RD_LINE  4'hE
`define CMD_MEM_WR_INV   4'hF

// Burst limits
`define EARLY_STOP_WORDS 8'h03
`define LINE_WORDS       8'h08
`define LINE_SHIFT       3

// Clocks without device select before a master abort
`define DEVSEL_TIMEOUT   3'h5

`endif

// >>> verification/pci_target_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-end target; wt sets the first ready edge, tg the on/off run length
module pci_target_model (
	input wire logic clk, frame_n, irdy_n, bp, pe,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe_n,
	input wire logic [2:0] wt,
	input wire logic [1:0] tg,
	output logic trdy_n = 1'b1, devsel_n = 1'b1, par_t = 1'b0, perr_t = 1'b1,
	output logic [31:0] ad_t = 32'h0, wsum = 32'h0
);
	int n = 0, k = 0, pc = 0;
	logic rd = 1'b0;
	wire logic act = !frame_n || !irdy_n;
	wire logic dn = act && !irdy_n && !trdy_n;
	wire logic go = act && !(dn && frame_n);
	// Released lines show the inverse of the wire, so stale data never matches
	always @(posedge clk) begin
		n = act ? n + 1 : 0;
		// Command bit zero is set for writes, clear for reads
		if (n == 1) rd = !cbe_n[0];
		k = n == 1 ? 0 : k + dn;
		par_t <= ^{ad, cbe_n} ^ (bp && dn && rd);
		if (dn && !rd) wsum <= wsum + ad;
		pc = dn && !rd && pe ? 2 : (pc > 0 ? pc - 1 : 0);
		perr_t <= pc != 1;
		ad_t <= rd && n > 1 && go ? 32'hC0DE0000 + k : ~ad;
		trdy_n <= !(go && n + 1 >= wt && (tg == 0 || (n + 1 - wt) / tg % 2 == 0));
		devsel_n <= !go;
	end
endmodule
`default_nettype wire

// >>> verification/pci_initiator_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "pci_init_consts.vh"
module pci_initiator_chk (
	input wire logic clk, resetn, req_valid, req_ready, rd_valid, done, trdy_n,
	input wire logic parity_error_detected, irdy_n_out, irdy_n_oe_n, ad_oe_n,
	input wire logic par_in, perr_n_in, perr_n_out, perr_n_oe_n,
	input wire logic [3:0] req_cmd, cbe_n_out,
	input wire logic [7:0] xfer_count,
	input wire logic [31:0] rd_data, ad_in, ad_out
);
	// Data phase views; read phases have the data lines released
	wire logic ph = !irdy_n_out && !irdy_n_oe_n && !trdy_n;
	wire logic rp = ph && ad_oe_n;
	wire logic wh = !irdy_n_out && !irdy_n_oe_n && !ad_oe_n;
	wire logic wp = wh && !trdy_n;
	wire logic pq = ^{ad_in, cbe_n_out};
	logic mwi;
	// Write and invalidate in flight, latched when taken
	always @(posedge clk)
		mwi <= resetn && (req_valid && req_ready ? req_cmd == `CMD_MEM_WR_INV : mwi);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_bad; rp ##1 par_in != $past(pq); endsequence
	property p_perr_two; s_bad |=> !perr_n_out && !perr_n_oe_n; endproperty
	a_perr_two: assert property (p_perr_two) else $error("perr late");
	// Back-to-back bad words keep the pin low; it must still be driven high before release
	property p_perr_pulse;
		$fell(perr_n_out) |-> !perr_n_oe_n ##[1:300] (perr_n_out && !perr_n_oe_n);
	endproperty
	a_perr_pulse: assert property (p_perr_pulse) else $error("perr shape");
	property p_sts_rd; s_bad |-> ##[1:3] parity_error_detected; endproperty
	a_sts_rd: assert property (p_sts_rd) else $error("read status");
	property p_sts_wr; $past(wp, 2) && !perr_n_in |-> ##[0:2] parity_error_detected; endproperty
	a_sts_wr: assert property (p_sts_wr) else $error("write status");
	property p_wr_hold; wh && trdy_n |=> $stable(ad_out) && !irdy_n_out; endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write hold");
	property p_rd; rp |=> rd_valid && rd_data == $past(ad_in); endproperty
	a_rd: assert property (p_rd) else $error("read word");
	property p_dual; req_cmd == `CMD_DUAL_ADDR |-> !req_ready; endproperty
	a_dual: assert property (p_dual) else $error("dual taken");
	property p_mwi; done && mwi |-> xfer_count[2:0] == 3'h0; endproperty
	a_mwi: assert property (p_mwi) else $error("line end");
endmodule
bind pci_initiator pci_initiator_chk chk_u (.*);
`default_nettype wire

// >>> verification/pci_master_wait_parity_termination_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pci_init_consts.vh"
module pci_master_wait_parity_termination_tb_top;
	logic clk = 0, resetn = 0, req_valid = 0, req_early_stop = 0, wr_valid = 0;
	logic parity_error_clear = 0, bp = 0, pe = 0;
	logic [3:0] req_cmd = 4'h0;
	logic [7:0] req_len = 8'h0;
	logic [31:0] wr_data = 32'h0;
	logic [2:0] wt = 3'h3;
	logic [1:0] tg = 2'h0;
	int fail_count = 0, comparisons = 0;
	wire logic req_ready, wr_ready, rd_valid, done, master_abort, parity_error_detected, busy;
	wire logic frame_n_out, frame_n_oe_n, irdy_n_out, irdy_n_oe_n, ad_oe_n, cbe_n_oe_n;
	wire logic par_out, par_oe_n, perr_n_out, perr_n_oe_n, trdy_n, devsel_n, par_t, perr_t;
	wire logic [3:0] cbe_n_out;
	wire logic [7:0] xfer_count;
	wire logic [31:0] rd_data, ad_out, ad_t, wsum;
	// Bus levels: pull-ups on controls, else whoever holds the enable
	wire logic frame_n = frame_n_oe_n | frame_n_out;
	wire logic irdy_n = irdy_n_oe_n | irdy_n_out;
	wire logic [3:0] cbe_n = cbe_n_oe_n ? 4'hF : cbe_n_out;
	wire logic [31:0] ad_in = ad_oe_n ? ad_t : ad_out;
	wire logic par_in = par_oe_n ? par_t : par_out;
	wire logic perr_n_in = perr_n_oe_n ? perr_t : perr_n_out;
	pci_initiator dut_u (.req_addr(32'h00001000), .req_be_n(4'h0), .stop_n(1'b1), .*);
	pci_target_model tgt_u (.ad(ad_in), .*);
	always #5 clk = ~clk;
	task stp;
		@(posedge clk);
		#1;
	endtask
	task chk(input logic [31:0] g, x);
		comparisons++;
		if (g !== x) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, x);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// One transfer: l asked, e expected; write words feed while ready
	task automatic run(input logic [3:0] c, input logic [7:0] l, e, input logic s,
			input logic [2:0] w, input logic [1:0] t, input logic b, p);
		int i = 0, r = 0, tk, wk, g = 0;
		logic [31:0] s0 = wsum;
		{wt, tg, bp, pe} = {w, t, b, p};
		parity_error_clear = 1;
		stp;
		{parity_error_clear, req_cmd, req_len, req_early_stop} = {1'b0, c, l, s};
		{req_valid, wr_data, wr_valid} = {1'b1, 32'h10000000, c[0]};
		repeat (300) begin
			tk = req_valid && req_ready;
			wk = wr_valid && wr_ready;
			stp;
			if (tk) req_valid = 0;
			if (wk) begin
				i++;
				wr_data = 32'h10000000 + i;
				wr_valid = i < l;
			end
			r += rd_valid;
			g = done;
			if (g) break;
		end
		{wr_valid, req_valid} = 2'h0;
		repeat (4) stp;
		chk(g, 1);
		chk({busy, master_abort}, 2'b00);
		chk(xfer_count, e);
		chk(c[0] ? i : r, e);
		// Target numbers its read words from C0DE0000, one per completed phase
		if (!c[0]) chk(rd_data, 32'hC0DE0000 + e - 32'h00000001);
		chk(wsum - s0, c[0] ? e * 32'h10000000 + e * (e - 1) / 2 : 0);
		chk(parity_error_detected, b | p);
	endtask
	task s_wait;
		for (int w = 3; w <= 6; w++) begin
			run(w[0] ? `CMD_IO_RD : `CMD_MEM_RD, 1, 1, 0, w, 0, 0, 0);
			run(w[0] ? `CMD_CFG_WR : `CMD_MEM_WR, 1, 1, 0, w, 0, 0, 0);
		end
	endtask
	task s_toggle;
		for (int t = 1; t <= 2; t++) begin
			run(`CMD_MEM_RD_MULT, 5, 5, 0, 3, t, 0, 0);
			run(`CMD_MEM_WR, 5, 5, 0, 4, t, 0, 0);
		end
	endtask
	task s_parity;
		logic [3:0] rc[6] = '{`CMD_IO_RD, `CMD_MEM_RD, `CMD_CFG_RD, `CMD_CFG_RD,
			`CMD_MEM_RD_MULT, `CMD_MEM_RD_LINE};
		logic [3:0] wc[4] = '{`CMD_IO_WR, `CMD_CFG_WR, `CMD_MEM_WR, `CMD_MEM_WR_INV};
		foreach (rc[j]) run(rc[j], j > 2 ? 3 : 1, j > 2 ? 3 : 1, 0, 3, 0, 1, 0);
		foreach (wc[j]) run(wc[j], j < 2 ? 1 : 4 << (j - 2), j < 2 ? 1 : 4 << (j - 2), 0, 3, 0, 0, 1);
	endtask
	task s_early;
		logic [3:0] ec[6] = '{`CMD_MEM_WR, `CMD_MEM_RD, `CMD_MEM_RD_MULT, `CMD_MEM_RD_LINE,
			`CMD_CFG_RD, `CMD_CFG_WR};
		foreach (ec[j]) run(ec[j], 6, j < 4 ? 3 : 6, 1, 4, 0, 0, 0);
		run(`CMD_MEM_WR_INV, 12, 8, 1, 3, 0, 0, 0);
	endtask
	task s_dual;
		{req_cmd, req_valid} = {`CMD_DUAL_ADDR, 1'b1};
		stp;
		chk(req_ready, 0);
		stp;
		chk(frame_n_oe_n, 1);
		req_valid = 0;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 resetn = 1;
		s_wait;
		s_toggle;
		s_parity;
		s_early;
		s_dual;
		test_done;
	end
	// Watchdog well past the expected run length
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
endmodule
`default_nettype wire
